// *** verilog/psc_top.sv ***
// Purpose: Power save controller: sleep/idle sequencing, wake module, regulators, doze
// Assumes: APB register access; wake_pin and wake interrupts are asynchronous
// Notes: presetn is the supply-monitor power-on reset
//
// Contract
// - Interrupt during entry defers, then wakes
// - Power-on reset clears state but presets fuse and pin sync
// - Wake pin low wakes from Sleep
// - Wake from module sets flag bit 0
// - Bit 15 enables the wake module
// - Bit 13 halts module in Idle
// - Bit 8 enables the pin sink
// - Unimplemented wake bits read zero
// - Sleep standby unless sleep-power bit set
// - Retention needs fuse zero and enable
// - Retention regulator used only in Sleep and regulator start-up
// - Retention sleep; main regulator restarts first
// - Fuse zero, enable, no power: retention
// - Fuse one disables retention regulator
// - Doze divides CPU clock only
// - Doze active only when enabled
// - Ratio field selects 1:1 to 1:128
// - Return-on-interrupt clears doze enable
// - Interrupt, reset or watchdog exits
// - Sleep stops system clock; Idle CPU
// - Clock source unchanged across Sleep
`timescale 1ns/10ps
`default_nettype none
module psc_top
   import psc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic power_save_instruction,
   input wire logic power_save_idle,
   input wire logic irq_pending,
   input wire logic wdt_timeout,
   input wire logic retention_fuse,
   input wire logic wake_pin_in,
   output logic wake_pin_out,
   output logic wake_pin_oe,
   output logic sys_clk_en,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic wake_event,
   output logic main_regulator_on,
   output logic main_regulator_full,
   output logic retention_regulator_on
);
   logic [1:0] pin_sync_reg, pin_sync_next;
   logic [1:0] irq_sync_reg, irq_sync_next;
   logic [1:0] wdt_sync_reg, wdt_sync_next;
   logic [15:0] ulp_reg, ulp_next;
   logic [15:0] rctl_reg, rctl_next;
   logic [15:0] cdiv_reg, cdiv_next;
   logic flag_reg, flag_next;
   logic fuse_reg, fuse_next;
   logic fuse_done_reg, fuse_done_next;
   psc_state_t state_reg, state_next;
   logic [7:0] regup_reg, regup_next;
   logic [6:0] doze_cnt_reg, doze_cnt_next;
   logic ret_mode_reg, ret_mode_next;
   logic [31:0] prdata_reg, prdata_next;
   psc_reg_ctl_t reg_ctl;
   logic wr, rd, pin_low, irq_s, wdt_s, ulp_active, ulp_wake, wake_any;
   logic [6:0] doze_max;

   // Two-stage synchronisers for the pin and async events
   always_comb begin
      pin_sync_next = {pin_sync_reg[0], wake_pin_in};
      irq_sync_next = {irq_sync_reg[0], irq_pending};
      wdt_sync_next = {wdt_sync_reg[0], wdt_timeout};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_sync_reg <= 2'h3;
         irq_sync_reg <= 2'h0;
         wdt_sync_reg <= 2'h0;
      end else if (clk_en) begin
         pin_sync_reg <= pin_sync_next;
         irq_sync_reg <= irq_sync_next;
         wdt_sync_reg <= wdt_sync_next;
      end
   end

   assign pin_low = ~pin_sync_reg[1];
   assign irq_s = irq_sync_reg[1];
   assign wdt_s = wdt_sync_reg[1];
   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_reg;

   // Module runs when enabled, unless halted in Idle
   assign ulp_active = ulp_reg[PSC_ULP_EN_BIT] & ~(ulp_reg[PSC_ULP_SIDL_BIT]
      & (state_reg == PSC_IDLE));
   assign ulp_wake = ulp_active & ulp_reg[PSC_ULP_SINK_BIT] & pin_low
      & (state_reg == PSC_SLEEP);
   assign wake_any = irq_s | wdt_s | ulp_wake;
   assign doze_max = 7'(({7'h0, 1'b1} << cdiv_reg[PSC_DOZE_HI:PSC_DOZE_LO]) - 8'd1);

   // Register file and status
   always_comb begin
      ulp_next = ulp_reg;
      rctl_next = rctl_reg;
      cdiv_next = cdiv_reg;
      flag_next = flag_reg;
      fuse_next = fuse_reg;
      fuse_done_next = 1'b1;
      prdata_next = prdata_reg;
      if (!fuse_done_reg) begin
         fuse_next = retention_fuse;
      end
      if (wr) begin
         case (paddr)
            PSC_OFF_ULPW: ulp_next = pwdata[15:0] & PSC_ULP_MASK;
            PSC_OFF_RCTL: rctl_next = pwdata[15:0] & PSC_RCTL_MASK;
            PSC_OFF_CDIV: cdiv_next = pwdata[15:0] & PSC_CDIV_MASK;
            PSC_OFF_IFLAG5: flag_next = pwdata[PSC_WAKE_FLAG_BIT];
            default: ;
         endcase
      end
      if (cdiv_reg[PSC_RET_ON_IRQ_BIT] && irq_s) begin
         cdiv_next[PSC_DOZE_EN_BIT] = 1'b0;
      end
      if (ulp_wake) begin
         flag_next = 1'b1;
      end
      if (rd) begin
         case (paddr)
            PSC_OFF_ULPW: prdata_next = {16'h0000, ulp_reg};
            PSC_OFF_RCTL: prdata_next = {16'h0000, rctl_reg};
            PSC_OFF_CDIV: prdata_next = {16'h0000, cdiv_reg};
            PSC_OFF_IFLAG5: prdata_next = {31'h0, flag_reg};
            PSC_OFF_STAT: prdata_next = {24'h0, fuse_reg, reg_ctl, 1'b0, state_reg[2:0]};
            default: prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Power state machine
   always_comb begin
      state_next = state_reg;
      regup_next = regup_reg;
      ret_mode_next = ret_mode_reg;
      case (state_reg)
         PSC_RUN: begin
            if (power_save_instruction) begin
               state_next = PSC_ENTER;
            end
         end
         PSC_ENTER: begin
            // Entry completes first; pending interrupt wakes next
            state_next = power_save_idle ? PSC_IDLE : PSC_SLEEP;
            ret_mode_next = ~fuse_reg & rctl_reg[PSC_RET_EN_BIT]
               & ~rctl_reg[PSC_SLP_PWR_BIT] & ~power_save_idle;
         end
         PSC_SLEEP: begin
            if (wake_any) begin
               regup_next = 8'(PSC_REGON_CYC);
               state_next = ret_mode_reg ? PSC_REGUP : PSC_RUN;
            end
         end
         PSC_IDLE: begin
            if (wake_any) begin
               state_next = PSC_RUN;
            end
         end
         PSC_REGUP: begin
            if (regup_reg == 8'h00) begin
               state_next = PSC_RUN;
               ret_mode_next = 1'b0;
            end else begin
               regup_next = regup_reg - 8'd1;
            end
         end
         default: state_next = PSC_RUN;
      endcase
   end

   // Doze divider for CPU clock enable
   always_comb begin
      doze_cnt_next = 7'h00;
      if (cdiv_reg[PSC_DOZE_EN_BIT] && doze_cnt_reg < doze_max) begin
         doze_cnt_next = doze_cnt_reg + 7'd1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ulp_reg <= PSC_ULP_RST;
         rctl_reg <= PSC_RCTL_RST;
         cdiv_reg <= PSC_CDIV_RST;
         flag_reg <= 1'b0;
         fuse_reg <= 1'b1;
         fuse_done_reg <= 1'b0;
         state_reg <= PSC_RUN;
         regup_reg <= 8'h00;
         doze_cnt_reg <= 7'h00;
         ret_mode_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         ulp_reg <= ulp_next;
         rctl_reg <= rctl_next;
         cdiv_reg <= cdiv_next;
         flag_reg <= flag_next;
         fuse_reg <= fuse_next;
         fuse_done_reg <= fuse_done_next;
         state_reg <= state_next;
         regup_reg <= regup_next;
         doze_cnt_reg <= doze_cnt_next;
         ret_mode_reg <= ret_mode_next;
         prdata_reg <= prdata_next;
      end
   end

   // Regulator selection
   always_comb begin
      reg_ctl.main_on = 1'b1;
      reg_ctl.main_full = 1'b1;
      reg_ctl.ret_on = 1'b0;
      if (state_reg == PSC_SLEEP) begin
         reg_ctl.main_full = rctl_reg[PSC_SLP_PWR_BIT];
         if (ret_mode_reg) begin
            reg_ctl.main_on = 1'b0;
            reg_ctl.ret_on = 1'b1;
         end
      end else if (state_reg == PSC_REGUP) begin
         reg_ctl.ret_on = 1'b1;
      end
   end

   assign main_regulator_on = reg_ctl.main_on;
   assign main_regulator_full = reg_ctl.main_full;
   assign retention_regulator_on = reg_ctl.ret_on;
   // Clock gates; source selection is untouched so it survives Sleep
   assign sys_clk_en = (state_reg != PSC_SLEEP) && (state_reg != PSC_REGUP);
   assign periph_clk_en = sys_clk_en;
   assign cpu_clk_en = (state_reg == PSC_RUN) && (doze_cnt_reg == 7'h00);
   assign wake_pin_out = 1'b0;
   assign wake_pin_oe = ulp_active & ulp_reg[PSC_ULP_SINK_BIT];
   assign wake_event = ulp_wake;
endmodule : psc_top
`default_nettype wire

// *** verilog/psc_pkg.sv ***
// Purpose: Shared constants and types for the power save controller
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are byte addresses
`default_nettype none
package psc_pkg;
   localparam logic [11:0] PSC_OFF_ULPW = 12'h000;
   localparam logic [11:0] PSC_OFF_RCTL = 12'h004;
   localparam logic [11:0] PSC_OFF_CDIV = 12'h008;
   localparam logic [11:0] PSC_OFF_IFLAG5 = 12'h00C;
   localparam logic [11:0] PSC_OFF_STAT = 12'h010;
   localparam logic [11:0] PSC_OFF_CMD = 12'h014;
   localparam int PSC_ULP_EN_BIT = 15;
   localparam int PSC_ULP_SIDL_BIT = 13;
   localparam int PSC_ULP_SINK_BIT = 8;
   localparam logic [15:0] PSC_ULP_MASK = 16'hA100;
   localparam logic [15:0] PSC_ULP_RST = 16'h0000;
   localparam int PSC_RET_EN_BIT = 12;
   localparam int PSC_SLP_PWR_BIT = 8;
   localparam logic [15:0] PSC_RCTL_MASK = 16'h1100;
   localparam logic [15:0] PSC_RCTL_RST = 16'h0000;
   localparam int PSC_RET_ON_IRQ_BIT = 15;
   localparam int PSC_DOZE_HI = 14;
   localparam int PSC_DOZE_LO = 12;
   localparam int PSC_DOZE_EN_BIT = 11;
   localparam logic [15:0] PSC_CDIV_MASK = 16'hF800;
   localparam logic [15:0] PSC_CDIV_RST = 16'h0000;
   localparam int PSC_WAKE_FLAG_BIT = 0;
   localparam int PSC_FUSE_RET_BIT = 2;
   localparam int PSC_CMD_SLEEP_BIT = 0;
   localparam int PSC_CMD_IDLE_BIT = 1;
   localparam int PSC_REGON_NS = 40;
   localparam int PSC_CLK_NS = 4;
   localparam int PSC_REGON_CYC = (PSC_REGON_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
   typedef enum logic [4:0] {
      PSC_RUN = 5'h01,
      PSC_ENTER = 5'h02,
      PSC_SLEEP = 5'h04,
      PSC_IDLE = 5'h08,
      PSC_REGUP = 5'h10
   } psc_state_t;
   typedef struct packed {
      logic main_on;
      logic main_full;
      logic ret_on;
   } psc_reg_ctl_t;
endpackage : psc_pkg
`default_nettype wire

// *** verification/psc_rc_model.sv ***
// Purpose: RC network on the wake pin
// Assumes: Charge input stands for the pin driven high
// Notes: Sink drains the level one step a cycle
`timescale 1ns/10ps
`default_nettype none
module psc_rc_model #(parameter int DIS = 40) (
   input wire logic pclk,
   input wire logic charge,
   input wire logic sink_oe,
   output logic pin
);
   int unsigned lvl = DIS;
   always @(posedge pclk) begin
      if (charge)
         lvl <= DIS;
      else if (sink_oe && lvl != 0)
         lvl <= lvl - 1;
   end
   assign pin = (lvl != 0);
endmodule : psc_rc_model
`default_nettype wire

// *** verification/psc_top_sva.sv ***
// Purpose: Port checks for psc_top
// Assumes: Fuse changes only in reset
// Notes: Bound to psc_top
`timescale 1ns/10ps
`default_nettype none
module psc_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic retention_fuse,
   input wire logic sys_clk_en,
   input wire logic cpu_clk_en,
   input wire logic periph_clk_en,
   input wire logic wake_event,
   input wire logic main_regulator_on,
   input wire logic main_regulator_full,
   input wire logic retention_regulator_on,
   input wire logic wake_pin_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_RST: assert property ($rose(presetn) |-> main_regulator_on && !wake_pin_oe)
      else $error("bad state after reset");
   AST_CPU: assert property (!sys_clk_en |-> !cpu_clk_en)
      else $error("cpu clock without system clock");
   AST_PER: assert property (periph_clk_en == sys_clk_en)
      else $error("peripheral clock differs");
   AST_FULL: assert property (main_regulator_full |-> main_regulator_on)
      else $error("full power while off");
   AST_MOFF: assert property (!main_regulator_on |-> retention_regulator_on && !sys_clk_en)
      else $error("main off without retention sleep");
   AST_RSLP: assert property (retention_regulator_on |-> !sys_clk_en)
      else $error("retention outside sleep");
   AST_FUSE: assert property (retention_fuse |-> !retention_regulator_on)
      else $error("retention with fuse set");
   AST_WSLP: assert property (wake_event |-> !sys_clk_en)
      else $error("wake event outside sleep");
   AST_WEXT: assert property (wake_event |-> ##[1:16] sys_clk_en)
      else $error("no exit after wake");
   cover property (wake_event);
   cover property (retention_regulator_on);
   cover property ($fell(sys_clk_en));
endmodule : psc_chk
bind psc_top psc_chk u_chk (.pclk(pclk), .presetn(presetn), .retention_fuse(retention_fuse),
   .sys_clk_en(sys_clk_en), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
   .wake_event(wake_event), .main_regulator_on(main_regulator_on),
   .main_regulator_full(main_regulator_full), .retention_regulator_on(retention_regulator_on),
   .wake_pin_oe(wake_pin_oe));
`default_nettype wire

// *** verification/power_save_controller_test.sv ***
// Purpose: Self-checking bench for psc_top
// Assumes: Seeded random wake control data
// Notes: Wake pin from the RC model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("ERROR %0t got %h exp %h", $time, a, e); end end
module power_save_controller_test;
   import psc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin;
   logic instr = 0, idle = 0, irq = 0, wdt = 0, fuse = 0, charge = 0, ce = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, d;
   logic pready, pslverr, oe, sys_en, cpu_en, per_en, wev, m_on, m_full, r_on;
   int failures = 0, n_checks = 0, cnt;
   psc_top u_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .power_save_instruction(instr),
      .power_save_idle(idle), .irq_pending(irq), .wdt_timeout(wdt), .retention_fuse(fuse),
      .wake_pin_in(pin), .wake_pin_out(), .wake_pin_oe(oe), .sys_clk_en(sys_en),
      .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .wake_event(wev), .main_regulator_on(m_on),
      .main_regulator_full(m_full), .retention_regulator_on(r_on));
   psc_rc_model #(.DIS(40)) u_rc (.pclk(pclk), .charge(charge), .sink_oe(oe), .pin(pin));
   initial forever #2 pclk = ~pclk;
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      `CHK({pslverr, rd}, {1'h0, e})
   endtask : rchk
   function automatic logic [31:0] ulp_exp(input logic [31:0] v);
      return v & {16'h0, PSC_ULP_MASK};
   endfunction : ulp_exp
   function automatic int doze_exp(input int i);
      return (i < 8) ? (256 >> i) : 256;
   endfunction : doze_exp
   task automatic nap(input logic id, input logic [31:0] rc, input int src, input logic [2:0] e);
      int n;
      irq <= (src == 0);
      wdt <= (src == 1);
      apb(1'h1, PSC_OFF_RCTL, rc);
      @(posedge pclk);
      idle <= id;
      instr <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         instr <= 1'h0;
         #1;
         n++;
      end while (!(cpu_en === 1'h0 && (id ? n > 1 : sys_en === 1'h0)) && n < 60);
      `CHK({m_on, m_full, r_on, sys_en, per_en, oe}, {e, id, id, src == 2})
      n = 0;
      do begin
         @(posedge pclk);
         irq <= 1'h0;
         wdt <= 1'h0;
         #1;
         n++;
      end while (!(sys_en === 1'h1 && cpu_en === 1'h1) && n < 200);
      if (src != 2) `CHK(n, e[0] ? PSC_REGON_CYC + 2 : 1)
      apb(1'h0, PSC_OFF_STAT, 32'h0);
      `CHK(rd[7:0], {fuse, 7'h61})
   endtask : nap
   task automatic rst(input logic f);
      presetn <= 1'h0;
      fuse <= f;
      repeat (4) @(posedge pclk);
      presetn <= 1'h1;
   endtask : rst
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   initial begin
      repeat (20000) @(posedge pclk);
      failures++;
      final_report;
   end
   initial begin
      void'($urandom(47884));
      rst(1'h0);
      rchk(PSC_OFF_ULPW, 32'h0);
      rchk(PSC_OFF_RCTL, 32'h0);
      rchk(PSC_OFF_CDIV, 32'h0);
      repeat (6) begin
         d = $urandom;
         apb(1'h1, PSC_OFF_ULPW, d);
         rchk(PSC_OFF_ULPW, ulp_exp(d));
         `CHK(oe, d[15] & d[8])
      end
      rchk(12'hFF0, 32'h0);
      ce <= 1'h0;
      apb(1'h1, PSC_OFF_ULPW, 32'hA100);
      ce <= 1'h1;
      rchk(PSC_OFF_ULPW, ulp_exp(d));
      for (int i = 0; i < 9; i++) begin
         apb(1'h1, PSC_OFF_CDIV, (i < 8) ? (32'h800 | (i << 12)) : 32'h7000);
         repeat (4) @(posedge pclk);
         cnt = 0;
         repeat (256) begin
            @(posedge pclk);
            #1;
            cnt += cpu_en;
         end
         `CHK(cnt, doze_exp(i))
      end
      for (int j = 0; j < 2; j++) begin
         d = j ? 32'h7800 : 32'hF800;
         apb(1'h1, PSC_OFF_CDIV, d);
         @(posedge pclk);
         irq <= 1'h1;
         repeat (5) @(posedge pclk);
         irq <= 1'h0;
         rchk(PSC_OFF_CDIV, j ? d : 32'hF000);
      end
      apb(1'h1, PSC_OFF_CDIV, 32'h0);
      apb(1'h1, PSC_OFF_ULPW, 32'hA100);
      nap(1'h1, 32'h1000, 0, 3'h6);
      apb(1'h1, PSC_OFF_ULPW, 32'h0);
      nap(1'h0, 32'h100, 1, 3'h6);
      nap(1'h0, 32'h0, 0, 3'h4);
      nap(1'h0, 32'h1000, 1, 3'h1);
      nap(1'h0, 32'h1100, 0, 3'h6);
      apb(1'h1, PSC_OFF_IFLAG5, 32'h0);
      @(posedge pclk);
      charge <= 1'h1;
      @(posedge pclk);
      charge <= 1'h0;
      apb(1'h1, PSC_OFF_ULPW, 32'h8100);
      nap(1'h0, 32'h0, 2, 3'h4);
      rchk(PSC_OFF_IFLAG5, 32'h1);
      rst(1'h1);
      nap(1'h0, 32'h1000, 0, 3'h4);
      nap(1'h0, 32'h1100, 1, 3'h6);
      final_report;
   end
endmodule : power_save_controller_test
`default_nettype wire
